// ==== design/timer_pair.sv ====
// Two timer/counters with control, mode and external interrupt flag logic
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module timer_pair
    import timer_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_ext_irq0_pin_n,
    input  wire logic       i_ext_irq1_pin_n,
    input  wire logic       i_counter_zero_pin,
    input  wire logic       i_counter_one_pin,
    input  wire logic       i_ack_timer0,
    input  wire logic       i_ack_timer1,
    input  wire logic       i_ack_ext_irq0,
    input  wire logic       i_ack_ext_irq1,
    output logic            o_timer0_ovf_flag,
    output logic            o_timer1_ovf_flag,
    output logic            o_ext_irq0_flag,
    output logic            o_ext_irq1_flag,
    output logic            o_irq
);

    // ******************************************************
    // State
    // ******************************************************
    logic [7:0]  timer_control;
    logic [7:0]  timer_mode;
    logic [7:0]  timer0_low_byte;
    logic [7:0]  timer0_high_byte;
    logic [7:0]  timer1_low_byte;
    logic [7:0]  timer1_high_byte;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic [7:0]  rdata;

    logic [7:0]  next_timer_control;
    logic [7:0]  next_timer_mode;
    logic [7:0]  next_timer0_low_byte;
    logic [7:0]  next_timer0_high_byte;
    logic [7:0]  next_timer1_low_byte;
    logic [7:0]  next_timer1_high_byte;
    logic [3:0]  next_irq_status;
    logic [3:0]  next_irq_mask;
    logic [7:0]  next_rdata;

    logic [3:0]  pin_level;
    logic [3:0]  pin_fall;

    timer_mode_t mode0;
    timer_mode_t mode1;
    logic        split;
    logic        en0;
    logic        en1;
    logic        inc0;
    logic        inc1;
    logic        inc_high0;
    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0]  step_high0;
    logic        ovf0;
    logic        ovf1;
    logic        ev_ext0;
    logic        ev_ext1;
    logic [3:0]  events;

    // ******************************************************
    // Helpers shared by both timers and both pins
    // ******************************************************
    // Run bit, gated by a high interrupt pin when gating is on
    function automatic logic gated_run(input logic run,
                                       input logic gate,
                                       input logic pin_high);
        gated_run = run && (!gate || pin_high);
    endfunction

    // Pin event: a fall in edge mode, a low sample in level mode
    function automatic logic pin_event(input logic edge_sel,
                                       input logic fall,
                                       input logic pin_high);
        pin_event = edge_sel ? fall : !pin_high;
    endfunction

    // ******************************************************
    // Pin sampling
    // ******************************************************
    pin_sampler #(
        .WIDTH (PIN_COUNT)
    ) u_pins (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_pins  ({i_counter_one_pin, i_counter_zero_pin,
                   i_ext_irq1_pin_n, i_ext_irq0_pin_n}),
        .o_level (pin_level),
        .o_fall  (pin_fall)
    );

    // ******************************************************
    // Count enables and steps
    // ******************************************************
    always_comb
    begin
        mode0 = timer_mode_t'(timer_mode[TM_TIMER0_MODE +: 2]);
        mode1 = timer_mode_t'(timer_mode[TM_TIMER1_MODE +: 2]);
        split = (mode0 == MODE_SPLIT);
        en0 = gated_run(timer_control[TC_TIMER0_RUN],
                        timer_mode[TM_TIMER0_GATE],
                        pin_level[PIN_EXT0]);
        en1 = gated_run(timer_control[TC_TIMER1_RUN],
                        timer_mode[TM_TIMER1_GATE],
                        pin_level[PIN_EXT1]);
        inc0 = en0 && (timer_mode[TM_TIMER0_SRC] ? pin_fall[PIN_CNT0] : 1'b1);
        inc1 = en1 && (timer_mode[TM_TIMER1_SRC] ? pin_fall[PIN_CNT1] : 1'b1)
               && (mode1 != MODE_SPLIT);
        // Split high byte: internal clock, timer 1 run bit only
        inc_high0 = split && timer_control[TC_TIMER1_RUN];
        step0 = timer_step(mode0, timer0_high_byte, timer0_low_byte);
        step1 = timer_step(mode1, timer1_high_byte, timer1_low_byte);
        step_high0 = {1'b0, timer0_high_byte} + 9'h001;
        ovf0 = inc0 && step0[16];
        ovf1 = (inc1 && step1[16]) || (inc_high0 && step_high0[8]);
    end

    // ******************************************************
    // Register and flag next values
    // ******************************************************
    always_comb
    begin
        next_timer_control    = timer_control;
        next_timer_mode       = timer_mode;
        next_timer0_low_byte  = timer0_low_byte;
        next_timer0_high_byte = timer0_high_byte;
        next_timer1_low_byte  = timer1_low_byte;
        next_timer1_high_byte = timer1_high_byte;
        next_irq_mask         = irq_mask;

        // Counting
        if (inc0)
        begin
            next_timer0_high_byte = step0[15:8];
            next_timer0_low_byte  = step0[7:0];
        end
        if (inc_high0)
        begin
            next_timer0_high_byte = step_high0[7:0];
        end
        if (inc1)
        begin
            next_timer1_high_byte = step1[15:8];
            next_timer1_low_byte  = step1[7:0];
        end

        // Software writes
        if (i_wr)
        begin
            case (i_addr)
                ADDR_TIMER_CONTROL: next_timer_control    = i_wdata;
                ADDR_TIMER_MODE:    next_timer_mode       = i_wdata;
                ADDR_TL0:           next_timer0_low_byte  = i_wdata;
                ADDR_TH0:           next_timer0_high_byte = i_wdata;
                ADDR_TL1:           next_timer1_low_byte  = i_wdata;
                ADDR_TH1:           next_timer1_high_byte = i_wdata;
                ADDR_IRQ_MASK:      next_irq_mask         = i_wdata[3:0];
                default:            next_irq_mask         = irq_mask;
            endcase
        end

        // Service entry clears, then hardware sets win
        if (i_ack_timer0)
        begin
            next_timer_control[TC_TIMER0_OVF] = 1'b0;
        end
        if (i_ack_timer1)
        begin
            next_timer_control[TC_TIMER1_OVF] = 1'b0;
        end
        if (ovf0)
        begin
            next_timer_control[TC_TIMER0_OVF] = 1'b1;
        end
        if (ovf1)
        begin
            next_timer_control[TC_TIMER1_OVF] = 1'b1;
        end

        // External interrupt 0
        if (timer_control[TC_EXT0_EDGE])
        begin
            if (i_ack_ext_irq0)
            begin
                next_timer_control[TC_EXT0_FLAG] = 1'b0;
            end
            if (pin_fall[PIN_EXT0])
            begin
                next_timer_control[TC_EXT0_FLAG] = 1'b1;
            end
        end
        else
        begin
            next_timer_control[TC_EXT0_FLAG] = !pin_level[PIN_EXT0];
        end

        // External interrupt 1
        if (timer_control[TC_EXT1_EDGE])
        begin
            if (i_ack_ext_irq1)
            begin
                next_timer_control[TC_EXT1_FLAG] = 1'b0;
            end
            if (pin_fall[PIN_EXT1])
            begin
                next_timer_control[TC_EXT1_FLAG] = 1'b1;
            end
        end
        else
        begin
            next_timer_control[TC_EXT1_FLAG] = !pin_level[PIN_EXT1];
        end

        // Sticky status, write one to clear, set wins
        ev_ext0 = pin_event(timer_control[TC_EXT0_EDGE], pin_fall[PIN_EXT0], pin_level[PIN_EXT0]);
        ev_ext1 = pin_event(timer_control[TC_EXT1_EDGE], pin_fall[PIN_EXT1], pin_level[PIN_EXT1]);
        events = 4'h0;
        events[IRQ_TIMER0] = ovf0;
        events[IRQ_TIMER1] = ovf1;
        events[IRQ_EXT0]   = ev_ext0;
        events[IRQ_EXT1]   = ev_ext1;
        next_irq_status = irq_status;
        if (i_wr && (i_addr == ADDR_IRQ_STATUS))
        begin
            next_irq_status = irq_status & ~i_wdata[3:0];
        end
        next_irq_status = next_irq_status | events;
    end

    // ******************************************************
    // Read data, standing for the cycle after the strobe only
    // ******************************************************
    always_comb
    begin
        next_rdata = 8'h00;
        if (i_rd)
        begin
            case (i_addr)
                ADDR_TIMER_CONTROL: next_rdata = timer_control;
                ADDR_TIMER_MODE:    next_rdata = timer_mode;
                ADDR_TL0:           next_rdata = timer0_low_byte;
                ADDR_TH0:           next_rdata = timer0_high_byte;
                ADDR_TL1:           next_rdata = timer1_low_byte;
                ADDR_TH1:           next_rdata = timer1_high_byte;
                ADDR_IRQ_STATUS:    next_rdata = {4'h0, irq_status};
                ADDR_IRQ_MASK:      next_rdata = {4'h0, irq_mask};
                default:            next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            rdata <= REG_RESET;
        end
        else if (i_ce)
        begin
            rdata <= next_rdata;
        end
    end

    // ******************************************************
    // Registers
    // ******************************************************
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            timer_control    <= REG_RESET;
            timer_mode       <= REG_RESET;
            timer0_low_byte  <= REG_RESET;
            timer0_high_byte <= REG_RESET;
            timer1_low_byte  <= REG_RESET;
            timer1_high_byte <= REG_RESET;
            irq_status       <= IRQ_RESET;
            irq_mask         <= IRQ_RESET;
        end
        else if (i_ce)
        begin
            timer_control    <= next_timer_control;
            timer_mode       <= next_timer_mode;
            timer0_low_byte  <= next_timer0_low_byte;
            timer0_high_byte <= next_timer0_high_byte;
            timer1_low_byte  <= next_timer1_low_byte;
            timer1_high_byte <= next_timer1_high_byte;
            irq_status       <= next_irq_status;
            irq_mask         <= next_irq_mask;
        end
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    assign o_rdata           = rdata;
    assign o_timer0_ovf_flag = timer_control[TC_TIMER0_OVF];
    assign o_timer1_ovf_flag = timer_control[TC_TIMER1_OVF];
    assign o_ext_irq0_flag   = timer_control[TC_EXT0_FLAG];
    assign o_ext_irq1_flag   = timer_control[TC_EXT1_FLAG];
    assign o_irq             = |(irq_status & irq_mask);

endmodule // timer_pair

// ==== design/timer_pkg.sv ====
// Constants, register map and a shared step function for the timer pair block
package timer_pkg;

    // ******************************************************
    // Register addresses
    // ******************************************************
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE    = 8'h89;
    localparam logic [7:0] ADDR_TL0           = 8'h8a;
    localparam logic [7:0] ADDR_TL1           = 8'h8b;
    localparam logic [7:0] ADDR_TH0           = 8'h8c;
    localparam logic [7:0] ADDR_TH1           = 8'h8d;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'hf8;
    localparam logic [7:0] ADDR_IRQ_MASK      = 8'hf9;

    // ******************************************************
    // Field positions
    // ******************************************************
    localparam int TC_TIMER1_OVF  = 7;
    localparam int TC_TIMER1_RUN  = 6;
    localparam int TC_TIMER0_OVF  = 5;
    localparam int TC_TIMER0_RUN  = 4;
    localparam int TC_EXT1_FLAG   = 3;
    localparam int TC_EXT1_EDGE   = 2;
    localparam int TC_EXT0_FLAG   = 1;
    localparam int TC_EXT0_EDGE   = 0;
    localparam int TM_TIMER1_GATE = 7;
    localparam int TM_TIMER1_SRC  = 6;
    localparam int TM_TIMER1_MODE = 4;
    localparam int TM_TIMER0_GATE = 3;
    localparam int TM_TIMER0_SRC  = 2;
    localparam int TM_TIMER0_MODE = 0;

    // Interrupt status bits and sampled pin indices
    localparam int IRQ_TIMER0 = 0;
    localparam int IRQ_TIMER1 = 1;
    localparam int IRQ_EXT0   = 2;
    localparam int IRQ_EXT1   = 3;
    localparam int PIN_EXT0   = 0;
    localparam int PIN_EXT1   = 1;
    localparam int PIN_CNT0   = 2;
    localparam int PIN_CNT1   = 3;
    localparam int PIN_COUNT  = 4;

    // ******************************************************
    // Reset values
    // ******************************************************
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [3:0] IRQ_RESET  = 4'h0;
    localparam logic [3:0] PIN_RESET  = 4'hf;

    // ******************************************************
    // Modes
    // ******************************************************
    typedef enum logic [1:0]
    {
        MODE_13BIT  = 2'h0,
        MODE_16BIT  = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT  = 2'h3
    } timer_mode_t;

    // One count step: returns {overflow, high byte, low byte}
    function automatic logic [16:0] timer_step(input timer_mode_t mode,
                                               input logic [7:0]  th,
                                               input logic [7:0]  tl);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        c13 = {1'b0, th, tl[4:0]} + 14'h0001;
        c16 = {1'b0, th, tl} + 17'h00001;
        c8  = {1'b0, tl} + 9'h001;
        case (mode)
            MODE_13BIT:  timer_step = {c13[13], c13[12:5], tl[7:5], c13[4:0]};
            MODE_16BIT:  timer_step = c16;
            MODE_RELOAD: timer_step = {c8[8], th, (c8[8] ? th : c8[7:0])};
            default:     timer_step = {c8[8], th, c8[7:0]};
        endcase
    endfunction

endpackage

// ==== design/pin_sampler.sv ====
// Synchronous sampling and falling-edge detection of input pins
`timescale 1ns/1ps
module pin_sampler
    import timer_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_fall
);

    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_level;
    logic [WIDTH-1:0] next_prev;

    // ******************************************************
    // Sampling
    // ******************************************************
    always_comb
    begin
        next_level = level;
        next_prev  = prev;
        if (i_ce)
        begin
            next_level = i_pins;
            next_prev  = level;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            level <= WIDTH'(PIN_RESET);
            prev  <= WIDTH'(PIN_RESET);
        end
        else
        begin
            level <= next_level;
            prev  <= next_prev;
        end
    end

    assign o_level = level;
    assign o_fall  = prev & ~level;

endmodule // pin_sampler

// ==== bench/timer_pair_asserts.sv ====
// Concurrent checks on the timer pair ports
`timescale 1ns/1ps
module timer_pair_asserts
    import timer_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_ext_irq0_pin_n,
    input  wire logic       i_ext_irq1_pin_n,
    input  wire logic       i_ack_timer0,
    input  wire logic       i_ack_timer1,
    input  wire logic       i_ack_ext_irq0,
    input  wire logic       o_timer0_ovf_flag,
    input  wire logic       o_timer1_ovf_flag,
    input  wire logic       o_ext_irq0_flag,
    input  wire logic       o_ext_irq1_flag
);
    // ****************************************
    // Shadow of control writes, edges since reset
    // ****************************************
    logic       wc;
    logic [7:0] ctl;
    logic [7:0] next_ctl;
    logic [2:0] up;
    logic [2:0] next_up;
    assign wc = i_wr && (i_addr == ADDR_TIMER_CONTROL);
    always_comb
    begin
        next_ctl = wc ? i_wdata : ctl;
        next_up  = (up == 3'h4) ? up : up + 3'h1;
        if (i_rst)
        begin
            next_ctl = REG_RESET;
            next_up  = 3'h0;
        end
    end
    always_ff @(posedge i_mclk)
    begin
        ctl <= next_ctl;
        up  <= next_up;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // ****************************************
    // Properties
    // ****************************************
    a_ext0_level_follow: assert property (up == 3'h4 && !$past(ctl[0])
        |-> o_ext_irq0_flag == !$past(i_ext_irq0_pin_n, 2)) else $error("ext0 level flag");
    a_ext1_level_follow: assert property (up == 3'h4 && !$past(ctl[2])
        |-> o_ext_irq1_flag == !$past(i_ext_irq1_pin_n, 2)) else $error("ext1 level flag");
    a_ext0_edge_set: assert property (up == 3'h4 && $past(ctl[0])
        && $past(i_ext_irq0_pin_n, 3) && !$past(i_ext_irq0_pin_n, 2)
        |-> o_ext_irq0_flag) else $error("ext0 fall not flagged");
    a_ext1_edge_set: assert property (up == 3'h4 && $past(ctl[2])
        && $past(i_ext_irq1_pin_n, 3) && !$past(i_ext_irq1_pin_n, 2)
        |-> o_ext_irq1_flag) else $error("ext1 fall not flagged");
    a_ext0_ack_clear: assert property (up == 3'h4 && $past(ctl[0]) && $past(i_ack_ext_irq0)
        && !$past(wc) && !($past(i_ext_irq0_pin_n, 3) && !$past(i_ext_irq0_pin_n, 2))
        |-> !o_ext_irq0_flag) else $error("ext0 ack did not clear");
    a_ovf_ack_clear: assert property (up != 3'h0 && !$past(ctl[4] | ctl[6]) && !$past(wc)
        |-> (!$past(i_ack_timer0) || !o_timer0_ovf_flag)
        && (!$past(i_ack_timer1) || !o_timer1_ovf_flag)) else $error("ovf ack did not clear");
    a_ovf_sw_write: assert property (up != 3'h0 && $past(wc) && !$past(ctl[4] | ctl[6])
        && !$past(i_ack_timer0 | i_ack_timer1) |-> o_timer1_ovf_flag == $past(i_wdata[7])
        && o_timer0_ovf_flag == $past(i_wdata[5])) else $error("ovf write lost");
    a_ovf_stop_hold: assert property (up != 3'h0 && !$past(ctl[4] | ctl[6]) && !$past(wc)
        && !$past(i_ack_timer0 | i_ack_timer1) |-> $stable(o_timer0_ovf_flag)
        && $stable(o_timer1_ovf_flag)) else $error("ovf flag moved while stopped");
endmodule // timer_pair_asserts

// ==== bench/pin_model.sv ====
// Pin source standing in for the interrupt and counter inputs
`timescale 1ns/1ps
module pin_model
(
    input  wire logic       i_mclk,
    input  wire logic [3:0] i_lvl,
    output logic      [3:0] o_pins
);
    // ****************************************
    // Pins idle high, change just after an edge
    // ****************************************
    initial o_pins = 4'hf;
    always @(posedge i_mclk)
        o_pins <= i_lvl;
endmodule // pin_model

// ==== bench/timer_pair_bench.sv ====
// Self-checking bench for the timer pair block
`timescale 1ns/1ps
module timer_pair_bench
    import timer_pkg::*;
;
    logic       i_mclk    = 1'b0;
    logic       i_rst     = 1'b1;
    logic [7:0] i_addr    = 8'h00;
    logic [7:0] i_wdata   = 8'h00;
    logic       i_wr      = 1'b0;
    logic       i_rd      = 1'b0;
    logic [3:0] ack       = 4'h0;
    logic       ce        = 1'b1;
    logic [3:0] lvl       = 4'hf;
    logic [3:0] pins;
    logic [3:0] flg;
    logic [7:0] o_rdata;
    logic       o_irq;
    logic [7:0] r;
    logic [7:0] th;
    logic [7:0] tl;
    logic [7:0] amap [9] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hf8, 8'hf9, 8'h87};
    int         n_errors  = 0;
    int         cmp_count = 0;
    int         k;
    int         n;
    always #10 i_mclk = ~i_mclk;
    pin_model PM (.i_mclk(i_mclk), .i_lvl(lvl), .o_pins(pins));
    timer_pair DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ext_irq0_pin_n(pins[PIN_EXT0]), .i_ext_irq1_pin_n(pins[PIN_EXT1]),
        .i_counter_zero_pin(pins[PIN_CNT0]), .i_counter_one_pin(pins[PIN_CNT1]),
        .i_ack_timer0(ack[0]), .i_ack_timer1(ack[1]), .i_ack_ext_irq0(ack[2]),
        .i_ack_ext_irq1(ack[3]), .o_timer0_ovf_flag(flg[0]), .o_timer1_ovf_flag(flg[1]),
        .o_ext_irq0_flag(flg[2]), .o_ext_irq1_flag(flg[3]), .o_irq(o_irq));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge i_mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask
    task automatic pulse(input int i);
        @(posedge i_mclk);
        ack[i] <= 1'b1;
        @(posedge i_mclk);
        ack[i] <= 1'b0;
        tick(1);
    endtask
    task automatic pin(input logic [3:0] v);
        @(posedge i_mclk);
        lvl <= v;
        tick(4);
    endtask
    task automatic wait_flag(input int i, output int c);
        c = 0;
        do
        begin
            tick(1);
            c++;
            if (c > 40)
            begin
                n_errors++;
                wrap_up();
            end
        end while (flg[i] !== 1'b1);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        k = $urandom(28874);
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        foreach (amap[j]) rd(amap[j], 8'h00);
        wr(8'h87, 8'h5a);
        rd(8'h87, 8'h00);
        r = 8'($urandom);
        wr(ADDR_TIMER_MODE, r);
        rd(ADDR_TIMER_MODE, r);
        for (int m = 0; m < 4; m++)
        begin
            r  = 8'($urandom);
            k  = $urandom % 8;
            th = (m < 2) ? 8'hff : r;
            tl = (m == 0) ? {r[7:5], 5'h1f - 5'(k)} : 8'hff - 8'(k);
            wr(ADDR_TIMER_MODE, 8'(m));
            wr(ADDR_TL0, tl);
            wr(ADDR_TH0, th);
            wr(ADDR_TIMER_CONTROL, 8'h10);
            wait_flag(IRQ_TIMER0, n);
            wr(ADDR_TIMER_CONTROL, 8'h20);
            chk(8'(n), 8'(k + 1));
            rd(ADDR_TL0, (m == 0) ? {r[7:5], 5'h02} : ((m == 2) ? r + 8'h02 : 8'h02));
            rd(ADDR_TH0, (m < 2) ? 8'h00 : r);
            rd(ADDR_TIMER_CONTROL, 8'h20);
            pulse(IRQ_TIMER0);
            chk(8'(flg[IRQ_TIMER0]), 8'h00);
        end
        chk(8'(o_irq), 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h01);
        tick(1);
        chk(8'(o_irq), 8'h01);
        wr(ADDR_IRQ_STATUS, 8'h01);
        tick(1);
        chk(8'(o_irq), 8'h00);
        wr(ADDR_TIMER_MODE, 8'h03);
        wr(ADDR_TH0, 8'hfd);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        wait_flag(IRQ_TIMER1, n);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        chk(8'(n), 8'h03);
        rd(ADDR_TH0, 8'h02);
        rd(ADDR_TL0, 8'h02);
        chk(8'(flg[IRQ_TIMER1]), 8'h00);
        wr(ADDR_TIMER_MODE, 8'hd0);
        wr(ADDR_TL1, 8'hfe);
        wr(ADDR_TH1, 8'hff);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        pin(4'h5);
        pin(4'hd);
        chk(8'(flg[IRQ_EXT1]), 8'h01);
        rd(ADDR_TL1, 8'hfe);
        pin(4'hf);
        pin(4'h7);
        rd(ADDR_TL1, 8'hff);
        pin(4'hf);
        pin(4'h7);
        chk(8'(flg[IRQ_TIMER1]), 8'h01);
        pulse(IRQ_TIMER1);
        chk(8'(flg[IRQ_TIMER1]), 8'h00);
        pin(4'hf);
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_TIMER_CONTROL, 8'h01 << (2 * i));
            pin(4'hf & ~(4'h1 << i));
            chk(8'(flg[IRQ_EXT0 + i]), 8'h01);
            pulse(IRQ_EXT0 + i);
            chk(8'(flg[IRQ_EXT0 + i]), 8'h00);
            pin(4'hf);
            pin(4'hf & ~(4'h1 << i));
            wr(ADDR_TIMER_CONTROL, 8'h01 << (2 * i));
            tick(1);
            chk(8'(flg[IRQ_EXT0 + i]), 8'h00);
            pin(4'hf);
        end
        wr(ADDR_TIMER_MODE, 8'hd1);
        wr(ADDR_TL0, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        ce <= 1'b0;
        repeat (6) @(posedge i_mclk);
        ce <= 1'b1;
        rd(ADDR_TL0, 8'h01);
        for (int j = 0; j < 300; j++)
        begin
            @(posedge i_mclk);
            lvl     <= 4'($urandom);
            ack     <= 4'($urandom) & 4'($urandom);
            i_wr    <= ($urandom % 8) == 0;
            i_addr  <= ADDR_TIMER_CONTROL;
            i_wdata <= 8'($urandom);
        end
        @(posedge i_mclk);
        i_wr <= 1'b0;
        ack  <= 4'h0;
        tick(2);
        wrap_up();
    end
endmodule // timer_pair_bench

bind timer_pair timer_pair_asserts CHK (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_ext_irq0_pin_n(i_ext_irq0_pin_n),
    .i_ext_irq1_pin_n(i_ext_irq1_pin_n), .i_ack_timer0(i_ack_timer0),
    .i_ack_timer1(i_ack_timer1), .i_ack_ext_irq0(i_ack_ext_irq0),
    .o_timer0_ovf_flag(o_timer0_ovf_flag), .o_timer1_ovf_flag(o_timer1_ovf_flag),
    .o_ext_irq0_flag(o_ext_irq0_flag), .o_ext_irq1_flag(o_ext_irq1_flag));
